// File: design/hpic_top.sv
// host port control register with its initialise command and both handshake channels
`timescale 1ns/1ps

//
// Function
// RULE1: host_port_control is an 8-bit register the host can write and read back.
// RULE2: the core has no port through which it could reach host_port_control.
// RULE3: hardware reset and software reset both clear every bit of host_port_control.
// RULE4: a one written to bit 7 starts the local initialise command.
// RULE5: the hardware clears bit 7 by itself once the command has run.
// RULE6: enables 0/0 only clear the init bit; tx enable alone sets host_tx_empty, clears core_rx_full.
// RULE7: rx enable alone clears host_rx_full and sets core_tx_empty.
// RULE8: both enables set both empty flags and clear both full flags.
// RULE9: tx enable in bit 1 with host_tx_empty set raises host_request_out, else no request.
// RULE10: a core word moves to the host only while core_tx_empty and host_rx_full are clear.
// RULE11: rx enable sits in bit 0 and resets to zero.
module hpic_top (
  // clock, reset, freeze
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  input  wire logic                                 ce,
  input  wire logic                                 soft_reset,
  // host register port
  input  wire logic                                 host_sel,
  input  wire logic                                 host_wr,
  input  wire logic                                 host_rd,
  input  wire logic [2:0]                           host_addr,
  input  wire logic [7:0]                           host_wdata,
  output logic      [7:0]                           host_rdata,
  // host data path
  input  wire logic                                 host_tx_write,
  input  wire logic [hpic_pkg::HPIC_WORD_WIDTH-1:0] host_tx_data,
  input  wire logic                                 host_rx_read,
  output logic      [hpic_pkg::HPIC_WORD_WIDTH-1:0] host_rx_data,
  output logic                                      host_tx_empty,
  output logic                                      host_rx_full,
  output logic                                      host_request_out,
  output logic                                      host_rx_request_out,
  // core data path
  input  wire logic                                 core_tx_write,
  input  wire logic [hpic_pkg::HPIC_WORD_WIDTH-1:0] core_tx_data,
  input  wire logic                                 core_rx_read,
  output logic      [hpic_pkg::HPIC_WORD_WIDTH-1:0] core_rx_data,
  output logic                                      core_tx_empty,
  output logic                                      core_rx_full,
  // control bits handed to the rest of the port
  output logic                                      host_endian,
  output logic      [1:0]                           host_flags,
  output logic                                      host_double_req
);

  typedef struct packed {
    hpic_pkg::hpic_control_type host_port_control;
    logic [7:0]                 rdata;
    logic                       tx_req;
    logic                       rx_req;
  } hpic_top_state_type;

  hpic_top_state_type state;
  hpic_top_state_type next_state;

  logic       control_write;
  logic       control_read;
  logic       run_init;
  logic [7:0] control_byte;

  // host-to-core and core-to-host channels
  hpic_chan_if h2c ();
  hpic_chan_if c2h ();

  assign control_write = host_sel && host_wr && (host_addr == hpic_pkg::HPIC_CONTROL_OFFSET);
  assign control_read  = host_sel && host_rd;
  assign control_byte  = state.host_port_control;

  // the command runs in the same cycle the init bit is seen set, the cycle after it is written
  assign run_init = state.host_port_control.init && !soft_reset; // RULE4

  // the enables pick which channel the command touches; neither leaves both alone
  assign h2c.init      = run_init && state.host_port_control.tx_request_enable; // RULE6 RULE8
  assign c2h.init      = run_init && state.host_port_control.rx_request_enable; // RULE7 RULE8
  assign h2c.restart   = soft_reset;
  assign c2h.restart   = soft_reset;

  assign h2c.src_write = host_tx_write;
  assign h2c.src_data  = host_tx_data;
  assign h2c.sink_read = core_rx_read;
  assign c2h.src_write = core_tx_write;
  assign c2h.src_data  = core_tx_data;
  assign c2h.sink_read = host_rx_read;

  hpic_channel u_h2c (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .ch    (h2c.chan)
  );

  hpic_channel u_c2h (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .ch    (c2h.chan)
  );

  always_comb begin
    next_state = state;

    // hardware clears the init bit once the command has been issued
    if (run_init) begin
      next_state.host_port_control.init = 1'h0; // RULE5
    end

    // a host write in the same cycle wins over the clear, so a fresh init request is lost only to a soft reset in that cycle
    if (control_write) begin
      next_state.host_port_control = hpic_pkg::hpic_control_type'(
        host_wdata & hpic_pkg::HPIC_WRITE_MASK); // RULE1 RULE11
    end

    // read data is captured on the strobe and stands until the next read
    if (control_read) begin
      if (host_addr == hpic_pkg::HPIC_CONTROL_OFFSET) begin
        next_state.rdata = control_byte; // RULE1
      end else begin
        next_state.rdata = hpic_pkg::HPIC_READ_ZERO;
      end
    end

    next_state.tx_req = state.host_port_control.tx_request_enable && h2c.src_empty; // RULE9
    next_state.rx_req = state.host_port_control.rx_request_enable && c2h.sink_full;

    if (soft_reset) begin
      next_state.host_port_control = hpic_pkg::HPIC_CONTROL_RESET; // RULE3
      next_state.tx_req            = 1'h0;
      next_state.rx_req            = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state.host_port_control <= hpic_pkg::HPIC_CONTROL_RESET; // RULE3 RULE11
      state.rdata             <= hpic_pkg::HPIC_READ_ZERO;
      state.tx_req            <= 1'h0;
      state.rx_req            <= 1'h0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // the core side sees only the channels; there is no core path to the control byte
  assign core_rx_data        = h2c.sink_data; // RULE2
  assign core_rx_full        = h2c.sink_full;
  assign core_tx_empty       = c2h.src_empty;
  assign host_tx_empty       = h2c.src_empty;
  assign host_rx_full        = c2h.sink_full;
  assign host_rx_data        = c2h.sink_data;

  assign host_rdata          = state.rdata;
  assign host_request_out    = state.tx_req;
  assign host_rx_request_out = state.rx_req;
  assign host_endian         = state.host_port_control.endian;
  assign host_flags          = {state.host_port_control.flag1, state.host_port_control.flag0};
  assign host_double_req     = state.host_port_control.double_req;

endmodule

// File: design/hpic_pkg.sv
// constants and types shared by the host port init control block
package hpic_pkg;

  // host address of the control register; the other host addresses are not held here
  localparam logic [2:0] HPIC_CONTROL_OFFSET = 3'h0;

  // field positions inside host_port_control
  localparam int HPIC_INIT_BIT    = 7;
  localparam int HPIC_RSVD_BIT    = 6;
  localparam int HPIC_ENDIAN_BIT  = 5;
  localparam int HPIC_FLAG1_BIT   = 4;
  localparam int HPIC_FLAG0_BIT   = 3;
  localparam int HPIC_DOUBLE_BIT  = 2;
  localparam int HPIC_TX_REQ_BIT  = 1;
  localparam int HPIC_RX_REQ_BIT  = 0;

  // reset values
  localparam logic [7:0] HPIC_CONTROL_RESET = 8'h00;
  localparam logic       HPIC_EMPTY_RESET   = 1'h1;
  localparam logic       HPIC_FULL_RESET    = 1'h0;
  localparam logic [7:0] HPIC_READ_ZERO     = 8'h00;

  // reserved bit reads back as zero
  localparam logic [7:0] HPIC_WRITE_MASK    = 8'hBF;

  // word width of the data path between host and core
  localparam int HPIC_WORD_WIDTH = 24;
  localparam logic [HPIC_WORD_WIDTH-1:0] HPIC_WORD_RESET = 24'h000000;

  typedef struct packed {
    logic init;
    logic reserved;
    logic endian;
    logic flag1;
    logic flag0;
    logic double_req;
    logic tx_request_enable;
    logic rx_request_enable;
  } hpic_control_type;

endpackage

// File: design/hpic_chan_if.sv
// carrier between the control logic and one handshake channel
`timescale 1ns/1ps
interface hpic_chan_if;
  logic                               init;
  logic                               restart;
  logic                               src_write;
  logic [hpic_pkg::HPIC_WORD_WIDTH-1:0] src_data;
  logic                               sink_read;
  logic                               src_empty;
  logic                               sink_full;
  logic [hpic_pkg::HPIC_WORD_WIDTH-1:0] sink_data;

  modport ctrl (
    output init,
    output restart,
    output src_write,
    output src_data,
    output sink_read,
    input  src_empty,
    input  sink_full,
    input  sink_data
  );

  modport chan (
    input  init,
    input  restart,
    input  src_write,
    input  src_data,
    input  sink_read,
    output src_empty,
    output sink_full,
    output sink_data
  );
endinterface

// File: design/hpic_channel.sv
// one double-buffered handshake channel: source register, sink register, empty and full flags
`timescale 1ns/1ps
module hpic_channel (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // control and data
  hpic_chan_if.chan ch
);

  typedef struct packed {
    logic                                 src_empty;
    logic                                 sink_full;
    logic [hpic_pkg::HPIC_WORD_WIDTH-1:0] src_data;
    logic [hpic_pkg::HPIC_WORD_WIDTH-1:0] sink_data;
  } hpic_chan_state_type;

  hpic_chan_state_type state;
  hpic_chan_state_type next_state;
  logic                move;

  // a word moves only while the source holds one and the sink is free
  assign move = !state.src_empty && !state.sink_full; // RULE10

  always_comb begin
    next_state = state;
    if (move) begin
      next_state.sink_data = state.src_data;
      next_state.sink_full = 1'h1;
      next_state.src_empty = 1'h1;
    end else if (ch.sink_read) begin
      next_state.sink_full = 1'h0;
    end
    // a write in the move cycle keeps the new word; the old one has already left
    if (ch.src_write) begin
      next_state.src_data  = ch.src_data;
      next_state.src_empty = 1'h0;
    end
    // initialise forgets any pending word in both halves
    if (ch.init) begin // RULE6 RULE7 RULE8
      next_state.src_empty = hpic_pkg::HPIC_EMPTY_RESET;
      next_state.sink_full = hpic_pkg::HPIC_FULL_RESET;
    end
    if (ch.restart) begin
      next_state.src_empty = hpic_pkg::HPIC_EMPTY_RESET;
      next_state.sink_full = hpic_pkg::HPIC_FULL_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state.src_empty <= hpic_pkg::HPIC_EMPTY_RESET;
      state.sink_full <= hpic_pkg::HPIC_FULL_RESET;
      state.src_data  <= hpic_pkg::HPIC_WORD_RESET;
      state.sink_data <= hpic_pkg::HPIC_WORD_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign ch.src_empty = state.src_empty;
  assign ch.sink_full = state.sink_full;
  assign ch.sink_data = state.sink_data;

endmodule

// File: verification/hpic_checker.sv
// port-level checks for the host port init control block
`timescale 1ns/1ps
module hpic_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       soft_reset,
  // host register port
  input wire logic       host_sel,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  // flags and control bits
  input wire logic       host_tx_empty,
  input wire logic       host_rx_full,
  input wire logic       host_request_out,
  input wire logic       core_tx_empty,
  input wire logic       core_rx_full,
  input wire logic       core_tx_write,
  input wire logic       host_endian,
  input wire logic [1:0] host_flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic wr0;
  logic go;
  assign wr0 = ce && !soft_reset && host_sel && host_wr && host_addr == 3'h0;
  assign go  = wr0 && host_wdata[7];
  a_soft_clear: assert property (ce && soft_reset |=> host_flags == 2'h0 && !host_endian
    && host_tx_empty && !host_rx_full && core_tx_empty && !core_rx_full) else $error("soft clear");
  a_write_bits: assert property (wr0 |=> host_endian == $past(host_wdata[5])
    && host_flags == $past(host_wdata[4:3])) else $error("write lost");
  a_read_rsvd: assert property (ce && host_sel && host_rd |=> !host_rdata[6])
    else $error("reserved bit set");
  a_read_unmapped: assert property (ce && host_sel && host_rd && host_addr != 3'h0
    |=> host_rdata == 8'h00) else $error("unmapped read");
  a_init_tx: assert property ((go && host_wdata[1]) ##1 (ce && !soft_reset)
    |=> host_tx_empty && !core_rx_full) else $error("init tx");
  a_init_rx: assert property ((go && host_wdata[0]) ##1 (ce && !soft_reset)
    |=> !host_rx_full && core_tx_empty) else $error("init rx");
  a_request_off: assert property (ce && !host_tx_empty |=> !host_request_out)
    else $error("request without empty");
  // a core write landing in the move cycle keeps the source full, so empty may stay low then
  a_move_gate: assert property ($rose(host_rx_full) |-> !$past(core_tx_empty)
    && (core_tx_empty || $past(core_tx_write))) else $error("bad move");
  cover property (go);
  cover property ($rose(host_rx_full));
  cover property ($rose(host_request_out));
endmodule
bind hpic_top hpic_checker u_chk (.clk, .rst_b, .ce, .soft_reset, .host_sel, .host_wr,
  .host_rd, .host_addr, .host_wdata, .host_rdata, .host_tx_empty, .host_rx_full,
  .host_request_out, .core_tx_empty, .core_rx_full, .core_tx_write, .host_endian, .host_flags);

// File: verification/hpic_host_model.sv
// host processor model on the byte-wide register port
`timescale 1ns/1ps
module hpic_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic            host_sel,
  output logic            host_wr,
  output logic            host_rd,
  output logic      [2:0] host_addr,
  output logic      [7:0] host_wdata,
  input  wire logic [7:0] host_rdata
);
  initial begin
    host_sel = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 3'h0;
    host_wdata = 8'h00;
  end
  // released lines show inverted data so a stale value is never mistaken for a live one
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    host_sel <= 1'b1;
    host_wr <= wr;
    host_rd <= !wr;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_sel <= 1'b0;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
    @(posedge clk);
    q = host_rdata;
  endtask
endmodule

// File: verification/test_host_port_init_control.sv
// self-checking bench for the host port init control block
`timescale 1ns/1ps
module test_host_port_init_control;
  localparam int W = hpic_pkg::HPIC_WORD_WIDTH;
  logic         clk, rst_b, ce, host_sel, host_wr, host_rd, host_tx_empty, host_rx_full;
  logic         host_request_out, core_tx_empty, core_rx_full, host_endian, host_double_req;
  logic         host_rx_request_out;
  logic [1:0]   host_flags;
  logic [2:0]   host_addr;
  logic [4:0]   stb;
  logic [7:0]   host_wdata, host_rdata, q;
  logic [W-1:0] host_tx_data, host_rx_data, core_tx_data, core_rx_data;
  int           bad_count, comparisons;
  // stb: soft reset, core read, core write, host read, host write
  hpic_top u_dut (.clk, .rst_b, .ce, .soft_reset(stb[4]), .host_sel, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_rdata, .host_tx_write(stb[0]), .host_tx_data,
    .host_rx_read(stb[1]), .host_rx_data, .host_tx_empty, .host_rx_full, .host_request_out,
    .host_rx_request_out, .core_tx_write(stb[2]), .core_tx_data, .core_rx_read(stb[3]),
    .core_rx_data, .core_tx_empty, .core_rx_full, .host_endian, .host_flags, .host_double_req);
  hpic_host_model u_host (.clk, .host_sel, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata);
  always #2 clk = ~clk;
  task automatic check(input string name, input logic [W-1:0] seen, input logic [W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic pulse(input logic [4:0] m, input int n);
    @(posedge clk);
    stb <= m;
    @(posedge clk);
    stb <= 5'h00;
    repeat (n) @(posedge clk);
  endtask
  task automatic test_access();
    u_host.access(1'b0, 3'h0, 8'h00, q);
    check("reset control", q, 8'h00);
    u_host.access(1'b1, 3'h0, 8'h7E, q);
    u_host.access(1'b1, 3'h1, 8'h00, q);
    u_host.access(1'b0, 3'h0, 8'h00, q);
    check("readback", q, 8'h3E);
    check("outputs", {host_endian, host_flags, host_double_req}, 4'hF);
    u_host.access(1'b0, 3'h4, 8'h00, q);
    check("unmapped", q, 8'h00);
    pulse(5'h10, 0);
    u_host.access(1'b0, 3'h0, 8'h00, q);
    check("soft reset", q, 8'h00);
  endtask
  task automatic test_init();
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      e = 2'(i);
      pulse(5'h10, 0);
      pulse(5'h05, 3);
      check("core word", core_rx_data, 24'h5A5A5A);
      // second words stay in the sources because both sinks are full
      pulse(5'h05, 2);
      u_host.access(1'b1, 3'h0, {6'h20, e}, q);
      repeat (2) @(posedge clk);
      check("flags", {host_tx_empty, host_rx_full, core_tx_empty, core_rx_full},
            {e[1], !e[0], e[0], !e[1]});
      check("rx request", host_rx_request_out, 1'b0);
      u_host.access(1'b0, 3'h0, 8'h00, q);
      check("init cleared", q, {6'h00, e});
      check("request", host_request_out, e[1]);
    end
  endtask
  task automatic test_move();
    pulse(5'h10, 0);
    u_host.access(1'b1, 3'h0, 8'h01, q);
    core_tx_data <= 24'h111111;
    pulse(5'h04, 3);
    check("word", host_rx_data, 24'h111111);
    check("rx request on", host_rx_request_out, 1'b1);
    core_tx_data <= 24'h222222;
    pulse(5'h04, 3);
    check("held", host_rx_data, 24'h111111);
    check("core_tx_empty", core_tx_empty, 1'b0);
    pulse(5'h02, 3);
    check("moved", host_rx_data, 24'h222222);
    // with the enable low even a soft reset and a host read must leave the word in place
    ce <= 1'b0;
    pulse(5'h12, 1);
    ce <= 1'b1;
    check("frozen", host_rx_full, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    stb = 5'h00;
    host_tx_data = 24'h5A5A5A;
    core_tx_data = 24'hA5A5A5;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    test_access();
    test_init();
    test_move();
    wrap_up();
  end
  // whole run needs well under a thousand cycles
  initial begin
    #8000;
    bad_count++;
    wrap_up();
  end
endmodule
